// ==== hdl/sync_serial_control_status.sv ====
`timescale 1ns/1ps
module sync_serial_control_status (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          go_write,
  input  wire logic                          go_wdata,
  input  wire logic                          ovr_read,
  input  wire logic                          ovr_write,
  input  wire logic                          ovr_wdata,
  input  wire logic                          sol_write,
  input  wire logic                          sol_wdata,
  input  wire logic                          ext_clk_sel,
  input  wire logic                          word16_sel,
  input  wire logic                          tail_mark_en,
  input  wire logic [sscs_pkg::WORD_W-1:0]   tx_word,
  input  wire logic                          sck_in,
  input  wire logic                          serial_data_in,
  output logic                               sck_out,
  output logic                               sck_oe,
  output logic                               serial_data_out_pin,
  output logic                               transfer_go_flag,
  output logic                               tail_mark_busy_flag,
  output logic                               overrun_flag,
  output logic                               serial_out_level_bit,
  output logic                               rx_valid,
  input  wire logic                          rx_ready,
  output logic [sscs_pkg::WORD_W-1:0]        rx_word
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_DONE} phase_t;

  typedef struct packed {
    phase_t                        phase;
    logic [4:0]                    cnt;
    logic [sscs_pkg::WORD_W-1:0]   sh;
    logic                          wide;
    logic [3:0]                    div;
    logic                          sck;
    logic                          sck_oe;
    logic [2:0]                    sync;
    logic                          lvl;
    logic                          sout;
    logic                          go;
    logic                          mark;
    logic                          ovr;
    logic                          armed;
    logic                          finished;
  } core_t;

  core_t s_q;
  core_t s_d;
  logic  agree;
  logic  ext_rise;
  logic  ext_fall;
  logic  int_rise;
  logic  int_fall;
  logic  rise;
  logic  fall;
  logic  push;
  logic  buf_ready;
  logic  clr_ok;
  logic [sscs_pkg::WORD_W-1:0] push_word;

  always_comb begin
    s_d       = s_q;
    int_rise  = 1'b0;
    int_fall  = 1'b0;
    push      = 1'b0;
    // sync[0] feeds only sync[1]; edges judged on sync[1] and sync[2]
    s_d.sync  = {s_q.sync[1:0], sck_in};
    agree     = (s_q.sync[1] == s_q.sync[2]) && (s_q.sync[2] != s_q.lvl);
    ext_rise  = agree && s_q.sync[2];
    ext_fall  = agree && !s_q.sync[2];
    if (agree) begin
      s_d.lvl = s_q.sync[2];
    end
    s_d.sck_oe = !ext_clk_sel;
    if ((s_q.phase == ST_SHIFT || s_q.phase == ST_TAIL) && !ext_clk_sel) begin
      if (s_q.div == sscs_pkg::SCK_HALF_LAST) begin
        s_d.div  = 4'h0;
        s_d.sck  = !s_q.sck;
        int_rise = !s_q.sck;
        int_fall = s_q.sck;
      end else begin
        s_d.div = s_q.div + 4'h1;
      end
    end else begin
      s_d.div = 4'h0;
      s_d.sck = sscs_pkg::SCK_IDLE;
    end
    rise = ext_clk_sel ? ext_rise : int_rise;
    fall = ext_clk_sel ? ext_fall : int_fall;
    push_word = s_q.wide ? s_q.sh : {8'h00, s_q.sh[15:8]};

    case (s_q.phase)
      ST_IDLE: begin
        if (go_write && go_wdata) begin  // [RULE1] [RULE2]
          s_d.phase    = ST_SHIFT;
          s_d.go       = 1'b1;
          s_d.finished = 1'b0;
          s_d.wide     = word16_sel;
          s_d.sh       = tx_word;
          s_d.sout     = tx_word[0];
          s_d.cnt      = word16_sel ? sscs_pkg::BITS_WORD : sscs_pkg::BITS_BYTE;
        end else if (sol_write) begin
          s_d.sout = sol_wdata;  // [RULE7]
        end
      end
      ST_SHIFT: begin
        if (rise) begin
          s_d.sh  = {serial_data_in, s_q.sh[15:1]};
          s_d.cnt = s_q.cnt - 5'h01;
          if (s_q.cnt == 5'h01) begin
            if (tail_mark_en) begin
              s_d.phase = ST_TAIL;
              s_d.mark  = 1'b1;  // [RULE3]
              s_d.cnt   = sscs_pkg::TAIL_BITS;
            end else begin
              s_d.phase = ST_DONE;
            end
          end
        end else if (fall) begin
          s_d.sout = s_q.sh[0];
        end
      end
      ST_TAIL: begin
        if (fall) begin
          s_d.sout = sscs_pkg::TAIL_LEVEL;
        end else if (rise) begin
          s_d.cnt = s_q.cnt - 5'h01;
          if (s_q.cnt == 5'h01) begin
            s_d.phase = ST_DONE;
            s_d.mark  = 1'b0;  // [RULE3]
          end
        end
      end
      ST_DONE: begin
        // Hold until the buffer takes the word, so a stalled reader loses nothing
        push = 1'b1;
        if (buf_ready) begin
          s_d.phase    = ST_IDLE;
          s_d.go       = 1'b0;  // [RULE8]
          s_d.finished = 1'b1;
        end
      end
      default: begin
        s_d.phase = ST_IDLE;
      end
    endcase

    // Read of a set flag arms the clear; a one written never clears
    clr_ok = ovr_write && !ovr_wdata && s_q.armed;  // [RULE4] [RULE6]
    if (ovr_read && s_q.ovr) begin
      s_d.armed = 1'b1;
    end
    if (clr_ok) begin
      s_d.ovr   = 1'b0;
      s_d.armed = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (ext_clk_sel && s_q.phase == ST_IDLE && s_q.finished && (ext_rise || ext_fall)) begin
      s_d.ovr = 1'b1;  // [RULE5]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.phase <= ST_IDLE;
      s_q.sck   <= sscs_pkg::SCK_IDLE;
      s_q.sout  <= sscs_pkg::SOUT_RESET;
      s_q.lvl   <= 1'b1;
      s_q.sync  <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  pair_buffer u_rx_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (push_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_word)
  );

  assign sck_out              = s_q.sck;
  assign sck_oe               = s_q.sck_oe;
  assign serial_data_out_pin  = s_q.sout;
  assign serial_out_level_bit = s_q.sout;  // [RULE7]
  assign transfer_go_flag     = s_q.go;    // [RULE2]
  assign tail_mark_busy_flag  = s_q.mark;
  assign overrun_flag         = s_q.ovr;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_go_starts: assert property (s_q.phase == ST_IDLE && go_write && go_wdata // [RULE1]
    |=> transfer_go_flag && s_q.phase == ST_SHIFT) else $error("go write did not start");
  a_zero_write_inert: assert property (s_q.phase == ST_IDLE && go_write && !go_wdata // [RULE2]
    && !sol_write |=> !transfer_go_flag && $stable(serial_data_out_pin))
    else $error("zero go write had effect");
  a_go_tracks_phase: assert property (transfer_go_flag == (s_q.phase != ST_IDLE)) // [RULE2]
    else $error("go flag does not track activity");
  a_mark_only_tail: assert property (tail_mark_busy_flag == (s_q.phase == ST_TAIL)) // [RULE3]
    else $error("tail mark flag wrong");
  a_ovr_clear_armed: assert property ($fell(overrun_flag) // [RULE4]
    |-> $past(s_q.armed) && $past(ovr_write) && !$past(ovr_wdata))
    else $error("overrun cleared without read");
  a_ovr_one_write: assert property (overrun_flag && ovr_write && ovr_wdata // [RULE6]
    |=> overrun_flag) else $error("writing one cleared overrun");
  a_ovr_sets: assert property (ext_clk_sel && s_q.phase == ST_IDLE && s_q.finished // [RULE5]
    && agree |=> overrun_flag) else $error("late clock edge missed");
  a_ovr_no_internal: assert property (!ext_clk_sel && !overrun_flag |=> !overrun_flag) // [RULE5]
    else $error("overrun set on internal clock");
  a_sol_drives: assert property (s_q.phase == ST_IDLE && sol_write && !go_write // [RULE7]
    |=> serial_data_out_pin == $past(sol_wdata)) else $error("level write not driven");
  a_go_ends: assert property (s_q.phase == ST_DONE && buf_ready // [RULE8]
    |=> !transfer_go_flag ##1 (!transfer_go_flag || $past(go_write && go_wdata)))
    else $error("go not cleared");
endmodule

// ==== hdl/sscs_pkg.sv ====
// Operation
// RULE1: A one written to the transfer go flag starts a serial transfer.
// RULE2: The go flag reads one while a transfer runs and zero once it stops, and a zero write does nothing.
// RULE3: The tail mark busy flag is one only while a tail mark is sent, zero when idle or moving data.
// RULE4: Overrun clears only when software writes zero after it has read the flag as one.
// RULE5: With the external clock selected, clock edges after a finished transfer set overrun.
// RULE6: A write can only clear overrun; writing one leaves it unchanged.
// RULE7: The serial out level bit drives the serial data out pin and reads back the pin's level.
// RULE8: The go flag returns to zero by itself when the transfer and any tail mark are done; here it stays one until the receive buffer takes the word.
package sscs_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SCK_HALF_NS    = 160;
  localparam int unsigned SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SCK_HALF_LAST  = 4'(SCK_HALF_CYC - 1);
  localparam int unsigned WORD_W         = 16;
  localparam logic [4:0]  BITS_BYTE      = 5'h08;
  localparam logic [4:0]  BITS_WORD      = 5'h10;
  localparam logic [4:0]  TAIL_BITS      = 5'h02;
  localparam logic        TAIL_LEVEL     = 1'b1;
  localparam logic        SOUT_RESET     = 1'b0;
  localparam logic        SCK_IDLE       = 1'b1;
  localparam int unsigned BUF_DEPTH      = 2;
endpackage

// ==== hdl/pair_buffer.sv ====
`timescale 1ns/1ps
module pair_buffer (
  input  wire logic                            core_clk,
  input  wire logic                            rst_b,
  input  wire logic                            in_valid,
  output logic                                 in_ready,
  input  wire logic [sscs_pkg::WORD_W-1:0]     in_data,
  output logic                                 out_valid,
  input  wire logic                            out_ready,
  output logic [sscs_pkg::WORD_W-1:0]          out_data
);
  typedef struct packed {
    logic [1:0]                        cnt;
    logic                              vld;
    logic [sscs_pkg::WORD_W-1:0]       slot0;
    logic [sscs_pkg::WORD_W-1:0]       slot1;
  } buf_t;

  buf_t s_q;
  buf_t s_d;
  logic take;
  logic give;

  always_comb begin
    s_d  = s_q;
    take = in_valid && (s_q.cnt < 2'(sscs_pkg::BUF_DEPTH));
    give = out_ready && (s_q.cnt != 2'h0);
    // Head always sits in slot0 so the output comes straight off a flop
    if (give) begin
      s_d.slot0 = s_q.slot1;
    end
    if (take) begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && give)) begin
        s_d.slot0 = in_data;
      end else begin
        s_d.slot1 = in_data;
      end
    end
    s_d.cnt = 2'(s_q.cnt + {1'b0, take} - {1'b0, give});
    // Valid kept in its own flop so the output needs no decode
    s_d.vld = (s_d.cnt != 2'h0);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.cnt < 2'(sscs_pkg::BUF_DEPTH);
  assign out_valid = s_q.vld;
  assign out_data  = s_q.slot0;
endmodule

// ==== testbench/serial_partner.sv ====
`timescale 1ns/1ps
module serial_partner (
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       frame,
  input  wire logic       fire,
  input  wire logic [4:0] n_clk,
  input  wire logic       serial_data_out,
  output logic            sck_in,
  output logic            serial_data_in,
  output logic [15:0]     captured
);
  localparam logic [15:0] PATTERN = 16'ha5c3;
  logic sck;
  int   idx;
  int   cap_n;
  assign sck = sck_oe ? sck_out : sck_in;
  initial begin
    sck_in = 1'b1;
    serial_data_in = 1'b0;
    idx = 0;
    cap_n = 0;
    captured = 16'h0000;
  end
  // Clock stands high between bursts
  always @(posedge fire) begin
    repeat (n_clk) begin
      #160 sck_in = 1'b0;
      #160 sck_in = 1'b1;
    end
  end
  always @(posedge frame) begin
    idx = 0;
    cap_n = 0;
    captured = 16'h0000;
  end
  // Rising edge takes data out, LSB first; tail bits are not data
  always @(posedge sck) begin
    if (frame && cap_n < 16) begin
      captured = {serial_data_out, captured[15:1]};
      cap_n = cap_n + 1;
    end
  end
  // Falling edge shifts next bit out, LSB first
  always @(negedge sck) begin
    if (frame && idx < 16) begin
      serial_data_in = PATTERN[idx];
      idx = idx + 1;
    end else begin
      serial_data_in = ~serial_data_in;
    end
  end
  // Released line must not keep the old bit
  always @(negedge frame) serial_data_in = ~serial_data_in;
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`define CHECK(g, e) begin check_count += 1; if ((g) !== (e)) begin num_errors += 1; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        core_clk, rst_b, go_write, go_wdata, ovr_read, ovr_write, ovr_wdata;
  logic        sol_write, sol_wdata, ext_clk_sel, word16_sel, tail_mark_en, sck_in;
  logic        serial_data_in, sck_out, sck_oe, serial_data_out_pin, transfer_go_flag;
  logic        tail_mark_busy_flag, overrun_flag, serial_out_level_bit, rx_valid, rx_ready;
  logic [15:0] tx_word, rx_word;
  logic        fire;
  logic [4:0]  n_clk;
  logic [15:0] captured;
  logic        tail_seen = 1'b0;
  logic        tail_bad = 1'b0;
  int          num_errors = 0;
  int          check_count = 0;

  sync_serial_control_status DUT (.core_clk(core_clk), .rst_b(rst_b), .go_write(go_write),
    .go_wdata(go_wdata), .ovr_read(ovr_read), .ovr_write(ovr_write), .ovr_wdata(ovr_wdata),
    .sol_write(sol_write), .sol_wdata(sol_wdata), .ext_clk_sel(ext_clk_sel),
    .word16_sel(word16_sel), .tail_mark_en(tail_mark_en), .tx_word(tx_word),
    .sck_in(sck_in), .serial_data_in(serial_data_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .serial_data_out_pin(serial_data_out_pin), .transfer_go_flag(transfer_go_flag),
    .tail_mark_busy_flag(tail_mark_busy_flag), .overrun_flag(overrun_flag),
    .serial_out_level_bit(serial_out_level_bit), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_word(rx_word));
  serial_partner far_end (.sck_out(sck_out), .sck_oe(sck_oe), .frame(transfer_go_flag),
    .fire(fire), .n_clk(n_clk), .serial_data_out(serial_data_out_pin), .sck_in(sck_in),
    .serial_data_in(serial_data_in), .captured(captured));

  always #20 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    if (tail_mark_busy_flag === 1'b1) begin
      tail_seen <= 1'b1;
      // Tail level is due once the clock has dropped into the tail
      if (sck_out === 1'b0 && serial_data_out_pin !== 1'b1) tail_bad <= 1'b1;
    end
  end

  // Strobe order: go, ovr write, ovr read, sol
  task automatic pulse(input logic [3:0] sel, input logic val);
    @(negedge core_clk);
    {go_write, ovr_write, ovr_read, sol_write} = sel;
    {go_wdata, ovr_wdata, sol_wdata} = {3{val}};
    @(negedge core_clk);
    {go_write, ovr_write, ovr_read, sol_write} = 4'h0;
    @(negedge core_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (transfer_go_flag !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK(rx_word, exp)
    rx_ready = 1'b1;
    @(negedge core_clk);
    rx_ready = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors += 1;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    core_clk = 0; rst_b = 0; fire = 0; n_clk = 5'h00; rx_ready = 0; tx_word = 16'h0081;
    {go_write, go_wdata, ovr_read, ovr_write, ovr_wdata, sol_write, sol_wdata} = 7'h00;
    {ext_clk_sel, word16_sel, tail_mark_en} = 3'h0;
    repeat (12) @(negedge core_clk);
    rst_b = 1;
    @(negedge core_clk);
    `CHECK(transfer_go_flag, 1'b0)
    `CHECK(tail_mark_busy_flag, 1'b0)
    `CHECK(serial_data_out_pin, 1'b0)
    `CHECK(sck_out, 1'b1)
    `CHECK(sck_oe, 1'b1)
    `CHECK(rx_valid, 1'b0)
    pulse(4'h1, 1'b1);
    `CHECK(serial_data_out_pin, 1'b1)
    `CHECK(serial_out_level_bit, 1'b1)
    pulse(4'h1, 1'b0);
    `CHECK(serial_data_out_pin, 1'b0)
    $display("test level done");
    pulse(4'h8, 1'b0);
    `CHECK(transfer_go_flag, 1'b0)
    pulse(4'h8, 1'b1);
    `CHECK(transfer_go_flag, 1'b1)
    `CHECK(serial_data_out_pin, 1'b1)
    wait_idle();
    `CHECK(transfer_go_flag, 1'b0)
    `CHECK(tail_seen, 1'b0)
    `CHECK(captured, 16'h8100)
    $display("test byte done");
    tx_word = 16'h1234; word16_sel = 1; tail_mark_en = 1;
    pulse(4'h8, 1'b1);
    `CHECK(serial_data_out_pin, 1'b0)
    wait_idle();
    `CHECK(tail_seen, 1'b1)
    `CHECK(tail_bad, 1'b0)
    `CHECK(captured, 16'h1234)
    `CHECK(tail_mark_busy_flag, 1'b0)
    $display("test word tail done");
    word16_sel = 0; tail_mark_en = 0; ext_clk_sel = 1;
    pulse(4'h8, 1'b1);
    n_clk = 5'h08; fire = 1;
    // Buffer already holds two words, so this one must wait
    repeat (120) @(negedge core_clk);
    `CHECK(transfer_go_flag, 1'b1)
    `CHECK(overrun_flag, 1'b0)
    `CHECK(sck_oe, 1'b0)
    `CHECK(sck_out, 1'b1)
    `CHECK(rx_valid, 1'b1)
    pop(16'h00c3);
    pop(16'ha5c3);
    pop(16'h00c3);
    wait_idle();
    `CHECK(transfer_go_flag, 1'b0)
    `CHECK(captured, 16'h3400)
    $display("test buffer done");
    fire = 0; n_clk = 5'h01;
    @(negedge core_clk);
    fire = 1;
    repeat (30) @(negedge core_clk);
    `CHECK(overrun_flag, 1'b1)
    pulse(4'h4, 1'b0);
    `CHECK(overrun_flag, 1'b1)
    pulse(4'h2, 1'b1);
    pulse(4'h4, 1'b1);
    `CHECK(overrun_flag, 1'b1)
    pulse(4'h4, 1'b0);
    `CHECK(overrun_flag, 1'b0)
    $display("test overrun done");
    results();
  end
endmodule
